/* File: design/pnvm_port.sv */
// parallel programming port: loads, page buffer, writes and read-back
// assumes all pins are synchronous to CLK_I and the port is in
// programming mode; the data bus wire is resolved outside from DATA_OE_O
`timescale 1ns/1ps
`default_nettype none
module pnvm_port
    import pnvm_pkg::*;
#(
    parameter int         WR_CNT    = WR_CYCLES, // write busy cycles
    parameter int         CE_CNT    = CE_CYCLES, // erase busy cycles
    parameter logic [7:0] SIG_BYTE0 = 8'h5a,     // arbitrary value
    parameter logic [7:0] SIG_BYTE1 = 8'h3c,     // arbitrary value
    parameter logic [7:0] SIG_BYTE2 = 8'h66,     // arbitrary value
    parameter logic [7:0] CAL_BYTE  = 8'h80      // arbitrary value
)(
    // clock and reset
    input  wire logic       CLK_I,
    input  wire logic       RST_I,
    // action and byte selects
    input  wire logic       ACTION_SELECT_HI_I,
    input  wire logic       ACTION_SELECT_LO_I,
    input  wire logic       BYTE_SELECT_ONE_I,
    input  wire logic       BYTE_SELECT_TWO_I,
    // strobes
    input  wire logic       LOAD_STROBE_I,
    input  wire logic       PAGE_LOAD_STROBE_I,
    input  wire logic       WRITE_STROBE_N_I,
    input  wire logic       OUTPUT_ENABLE_N_I,
    // data bus, split into its three signals
    input  wire logic [7:0] DATA_I,
    output logic      [7:0] DATA_O,
    output logic            DATA_OE_O,
    // status
    output logic            READY_BUSY_N_O
);
    ////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic                          ld_q;   // last load strobe
        logic                          pl_q;   // last page load strobe
        logic                          wr_q;   // last write strobe
        logic [7:0]                    cmd;    // loaded command
        logic [7:0]                    a_hi;   // address high byte
        logic [7:0]                    a_lo;   // address low byte
        logic [7:0]                    d_lo;   // data low byte
        logic [7:0]                    d_hi;   // data high byte
        logic [PAGE_WORDS-1:0][15:0]   pbuf;   // page buffer
        logic [FLASH_WORDS-1:0][15:0]  flash;  // flash array
        logic [EE_BYTES-1:0][7:0]      eep;    // eeprom array
        logic [7:0]                    f_lo;   // low fuses
        logic [7:0]                    f_hi;   // high fuses
        logic [7:0]                    f_ext;  // extended fuses
        logic [7:0]                    lock;   // lock bits
        logic [7:0]                    rd;     // read data out
        logic                          rd_oe;  // data bus drive
    } pnvm_state_t;

    pnvm_state_t st_ff;                        // registered state
    pnvm_state_t nxt_st;                       // next state
    logic        busy;                         // self-timed op running
    logic        ld_rise;                      // load strobe rising
    logic        pl_rise;                      // page load rising
    logic        wr_fall;                      // write strobe falling
    logic        wr_cmd;                       // command is a write
    logic        start;                        // write accepted
    logic        erase_go;                     // chip erase accepted
    logic        mode3;                        // both lock bits programmed (zero)
    logic [1:0]  act;                          // action select
    logic [1:0]  bsel;                         // byte select two/one
    logic [15:0] waddr;                        // full word address
    logic [FLASH_AW-1:0]         faddr;        // flash word index
    logic [FLASH_AW-PAGE_AW-1:0] fpage;        // flash page index
    logic [EE_AW-1:0]            eaddr;        // eeprom byte index
    logic [EE_AW-PAGE_AW-1:0]    epage;        // eeprom page index
    logic [PAGE_AW-1:0]          pidx;         // page buffer index

    ////////////////////////////////////////////////////////////////////
    // decode of pins and current state
    assign act     = {ACTION_SELECT_HI_I, ACTION_SELECT_LO_I};
    assign bsel    = {BYTE_SELECT_TWO_I, BYTE_SELECT_ONE_I};
    assign ld_rise = LOAD_STROBE_I & ~st_ff.ld_q;
    assign pl_rise = PAGE_LOAD_STROBE_I & ~st_ff.pl_q;
    assign wr_fall = ~WRITE_STROBE_N_I & st_ff.wr_q;
    assign wr_cmd  = (st_ff.cmd == CMD_WR_FLASH) || (st_ff.cmd == CMD_WR_EE)
                  || (st_ff.cmd == CMD_WR_FUSE) || (st_ff.cmd == CMD_WR_LOCK)
                  || (st_ff.cmd == CMD_ERASE);
    assign start    = wr_fall & ~busy & wr_cmd;
    assign erase_go = start & (st_ff.cmd == CMD_ERASE);
    assign mode3    = ~st_ff.lock[LOCK_LB_LO] & ~st_ff.lock[LOCK_LB_HI];
    assign waddr    = {st_ff.a_hi, st_ff.a_lo};
    assign faddr    = waddr[FLASH_AW-1:0];
    assign fpage    = waddr[FLASH_AW-1:PAGE_AW];
    assign eaddr    = waddr[EE_AW-1:0];
    assign epage    = waddr[EE_AW-1:PAGE_AW];
    assign pidx     = waddr[PAGE_AW-1:0];

    ////////////////////////////////////////////////////////////////////
    // next state: loads, page latch, writes and read mux
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.ld_q = LOAD_STROBE_I;
        nxt_st.pl_q = PAGE_LOAD_STROBE_I;
        nxt_st.wr_q = WRITE_STROBE_N_I;
        // load strobe: action select picks the target
        if (ld_rise)
        begin
            case (act)
                ACT_ADDR:
                begin
                    if (BYTE_SELECT_ONE_I)
                        nxt_st.a_hi = DATA_I;
                    else
                        nxt_st.a_lo = DATA_I;
                end
                ACT_DATA:
                begin
                    if (BYTE_SELECT_ONE_I)
                        nxt_st.d_hi = DATA_I;
                    else
                        nxt_st.d_lo = DATA_I;
                end
                ACT_CMD:
                begin
                    nxt_st.cmd = DATA_I;
                    // no operation drops any pending page data
                    if (DATA_I == CMD_NOP)
                        nxt_st.pbuf = {PAGE_WORDS{WORD_ERASED}};
                end
                default: ;                             // idle, no action
            endcase
        end
        // page load: latch data at the current word position
        if (pl_rise && (BYTE_SELECT_ONE_I || st_ff.cmd == CMD_WR_EE))
            nxt_st.pbuf[pidx] = {st_ff.d_hi, st_ff.d_lo};
        // accepted write strobe: store the data, the timer shows busy
        if (start)
        begin
            case (st_ff.cmd)
                CMD_WR_FLASH:
                    for (int i = 0; i < PAGE_WORDS; i++)
                        nxt_st.flash[{fpage, PAGE_AW'(i)}] = st_ff.pbuf[i];
                CMD_WR_EE:
                    for (int i = 0; i < PAGE_WORDS; i++)
                        nxt_st.eep[{epage, PAGE_AW'(i)}] =
                            st_ff.pbuf[i][7:0];
                CMD_WR_FUSE:
                begin
                    case (bsel)
                        WSEL_HI:  nxt_st.f_hi  = st_ff.d_lo;
                        WSEL_EXT: nxt_st.f_ext = st_ff.d_lo;
                        default:  nxt_st.f_lo  = st_ff.d_lo;
                    endcase
                end
                CMD_WR_LOCK:
                begin
                    // a write only programs bits, never erases them
                    nxt_st.lock = st_ff.lock & st_ff.d_lo;
                    if (mode3)
                        nxt_st.lock[LOCK_BLB_HI:LOCK_BLB_LO] =
                            st_ff.lock[LOCK_BLB_HI:LOCK_BLB_LO];
                end
                CMD_ERASE:
                begin
                    // fuses are kept, locks cleared with the arrays
                    nxt_st.flash = {FLASH_WORDS{WORD_ERASED}};
                    nxt_st.eep   = {EE_BYTES{BYTE_ERASED}};
                    nxt_st.lock  = BYTE_ERASED;
                end
                default: ;                             // not a write
            endcase
        end
        // read-back mux, registered onto the data bus
        nxt_st.rd    = BYTE_ZERO;
        nxt_st.rd_oe = 1'b0;
        if (!OUTPUT_ENABLE_N_I)
        begin
            case (st_ff.cmd)
                CMD_RD_FLASH:
                begin
                    nxt_st.rd_oe = 1'b1;
                    nxt_st.rd    = BYTE_SELECT_ONE_I ?
                                   st_ff.flash[faddr][15:8] :
                                   st_ff.flash[faddr][7:0];
                end
                CMD_RD_EE:
                begin
                    nxt_st.rd_oe = ~BYTE_SELECT_ONE_I;
                    nxt_st.rd    = st_ff.eep[eaddr];
                end
                CMD_RD_FUSE:
                begin
                    nxt_st.rd_oe = 1'b1;
                    case (bsel)
                        SEL_FUSE_LO:  nxt_st.rd = st_ff.f_lo;
                        SEL_FUSE_HI:  nxt_st.rd = st_ff.f_hi;
                        SEL_FUSE_EXT: nxt_st.rd = st_ff.f_ext;
                        default:      nxt_st.rd = st_ff.lock;
                    endcase
                end
                CMD_RD_SIG:
                begin
                    nxt_st.rd_oe = 1'b1;
                    if (BYTE_SELECT_ONE_I)
                        nxt_st.rd = (st_ff.a_lo == SIG_ADDR_0) ?
                                    CAL_BYTE : BYTE_ZERO;
                    else
                    begin
                        case (st_ff.a_lo)
                            SIG_ADDR_0: nxt_st.rd = SIG_BYTE0;
                            SIG_ADDR_1: nxt_st.rd = SIG_BYTE1;
                            SIG_ADDR_2: nxt_st.rd = SIG_BYTE2;
                            default:    nxt_st.rd = BYTE_ZERO;
                        endcase
                    end
                end
                default: ;                             // bus stays released
            endcase
        end
    end

    // state register
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            st_ff       <= '0;
            st_ff.ld_q  <= 1'b0;
            st_ff.wr_q  <= 1'b1;
            st_ff.pbuf  <= {PAGE_WORDS{WORD_ERASED}};
            st_ff.flash <= {FLASH_WORDS{WORD_ERASED}};
            st_ff.eep   <= {EE_BYTES{BYTE_ERASED}};
            st_ff.f_lo  <= BYTE_ERASED;
            st_ff.f_hi  <= BYTE_ERASED;
            st_ff.f_ext <= BYTE_ERASED;
            st_ff.lock  <= BYTE_ERASED;
        end
        else
            st_ff <= nxt_st;
    end

    ////////////////////////////////////////////////////////////////////
    // self-timed busy period
    pnvm_busy_timer #(
        .WR_CNT (WR_CNT),
        .CE_CNT (CE_CNT)
    ) u_timer (
        .CLK_I   (CLK_I),
        .RST_I   (RST_I),
        .start_i (start),
        .erase_i (erase_go),
        .busy_o  (busy)
    );

    // outputs
    assign READY_BUSY_N_O = ~busy;
    assign DATA_O         = st_ff.rd;
    assign DATA_OE_O      = st_ff.rd_oe;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    AST_BUSY_AFTER_WR: assert property (
        start |=> !READY_BUSY_N_O [*3])
        else $error("busy not shown after accepted write");
    AST_WR_IGNORED: assert property (
        (wr_fall && busy) |=> $stable(st_ff.flash) && $stable(st_ff.lock))
        else $error("write strobe acted while busy");
    AST_ADDR_HI: assert property (
        (ld_rise && act == ACT_ADDR && BYTE_SELECT_ONE_I)
        |=> st_ff.a_hi == $past(DATA_I))
        else $error("address high byte not loaded");
    AST_PAGE_LATCH: assert property (
        (pl_rise && BYTE_SELECT_ONE_I) |=>
        st_ff.pbuf[$past(pidx)] == $past({st_ff.d_hi, st_ff.d_lo}))
        else $error("page buffer not latched");
    AST_LOCK_ONLY_ERASE: assert property (
        !$past(erase_go) |-> (st_ff.lock & ~$past(st_ff.lock)) == '0)
        else $error("lock bit erased without chip erase");
    AST_BOOT_LOCK_HELD: assert property (
        (start && st_ff.cmd == CMD_WR_LOCK && mode3) |=>
        $stable(st_ff.lock[LOCK_BLB_HI:LOCK_BLB_LO]))
        else $error("boot lock changed in lock mode three");
    AST_FUSE_LO_READ: assert property (
        (!OUTPUT_ENABLE_N_I && st_ff.cmd == CMD_RD_FUSE
         && bsel == SEL_FUSE_LO) |=> DATA_OE_O && DATA_O == $past(st_ff.f_lo))
        else $error("low fuse read wrong");
    AST_FLASH_HI_READ: assert property (
        (!OUTPUT_ENABLE_N_I && st_ff.cmd == CMD_RD_FLASH && BYTE_SELECT_ONE_I)
        |=> DATA_OE_O && DATA_O == $past(st_ff.flash[faddr][15:8]))
        else $error("flash high byte read wrong");
    AST_NOP_CLEARS: assert property (
        (ld_rise && act == ACT_CMD && DATA_I == CMD_NOP) |=>
        st_ff.cmd == CMD_NOP && st_ff.pbuf == {PAGE_WORDS{WORD_ERASED}})
        else $error("no operation did not clear write state");
    AST_BUS_RELEASED: assert property (
        OUTPUT_ENABLE_N_I |=> !DATA_OE_O)
        else $error("bus driven with output enable high");
endmodule // pnvm_port
`default_nettype wire

/* File: design/pnvm_pkg.sv */
// constants shared by the parallel programming port
// assumes a single 50 MHz clock and inputs already synchronous to it
`default_nettype none
package pnvm_pkg;
    // clock period and self-timed write limits, in ns
    localparam int CLK_PERIOD_NS   = 20;
    localparam int T_WLRL_MAX_NS   = 1000;     // strobe low to busy low
    localparam int T_WLRH_MIN_NS   = 3700000;  // write busy, least
    localparam int T_WLRH_MAX_NS   = 4500000;  // write busy, most
    localparam int T_WLRH_CE_MIN_NS = 7500000; // erase busy, least
    localparam int T_WLRH_CE_MAX_NS = 9000000; // erase busy, most
    // cycle counts: least times round up
    localparam int WR_CYCLES = (T_WLRH_MIN_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
    localparam int CE_CYCLES = (T_WLRH_CE_MIN_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
    localparam int CNT_W     = 19;             // holds either busy count
    // action select coding for a load strobe pulse
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD  = 2'h2;
    // command byte coding
    localparam logic [7:0] CMD_NOP      = 8'h00;
    localparam logic [7:0] CMD_ERASE    = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EE    = 8'h11;
    localparam logic [7:0] CMD_RD_SIG   = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EE    = 8'h03;
    // byte select two/one coding for fuse and lock reads
    localparam logic [1:0] SEL_FUSE_LO  = 2'h0;
    localparam logic [1:0] SEL_FUSE_HI  = 2'h3;
    localparam logic [1:0] SEL_FUSE_EXT = 2'h2;
    localparam logic [1:0] SEL_LOCK     = 2'h1;
    // byte select two/one coding for fuse writes
    localparam logic [1:0] WSEL_HI      = 2'h1;
    localparam logic [1:0] WSEL_EXT     = 2'h2;
    // storage geometry (small model arrays)
    localparam int FLASH_AW = 4;               // flash word address bits
    localparam int EE_AW    = 4;               // eeprom byte address bits
    localparam int PAGE_AW  = 2;               // page buffer index bits
    localparam int FLASH_WORDS = 1 << FLASH_AW;
    localparam int EE_BYTES    = 1 << EE_AW;
    localparam int PAGE_WORDS  = 1 << PAGE_AW;
    // erased and reset values
    localparam logic [15:0] WORD_ERASED = 16'hffff;
    localparam logic [7:0]  BYTE_ERASED = 8'hff;
    localparam logic [7:0]  BYTE_ZERO   = 8'h00;
    // lock byte layout: two lock bits, then four boot lock bits
    localparam int LOCK_LB_LO   = 0;
    localparam int LOCK_LB_HI   = 1;
    localparam int LOCK_BLB_LO  = 2;
    localparam int LOCK_BLB_HI  = 5;
    // signature address range
    localparam logic [7:0] SIG_ADDR_0 = 8'h00;
    localparam logic [7:0] SIG_ADDR_1 = 8'h01;
    localparam logic [7:0] SIG_ADDR_2 = 8'h02;
endpackage
`default_nettype wire

/* File: design/pnvm_busy_timer.sv */
// self-timed busy counter for writes and chip erase
// assumes start is a one-cycle pulse only given while idle
`timescale 1ns/1ps
`default_nettype none
module pnvm_busy_timer
    import pnvm_pkg::*;
#(
    parameter int WR_CNT = WR_CYCLES,          // write busy length
    parameter int CE_CNT = CE_CYCLES           // erase busy length
)(
    // clock and reset
    input  wire logic CLK_I,
    input  wire logic RST_I,
    // control
    input  wire logic start_i,
    input  wire logic erase_i,
    // status
    output logic      busy_o
);
    // timer state
    typedef struct packed {
        logic             busy;                // operation in progress
        logic [CNT_W-1:0] cnt;                 // cycles left minus one
    } pnvm_tmr_t;

    pnvm_tmr_t st_ff;                          // registered state
    pnvm_tmr_t nxt_st;                         // next state

    ////////////////////////////////////////////////////////////////////
    // next state: load on start, count down, release at zero
    always_comb
    begin
        nxt_st = st_ff;
        if (start_i)
        begin
            nxt_st.busy = 1'b1;
            nxt_st.cnt  = erase_i ? CNT_W'(CE_CNT - 1) : CNT_W'(WR_CNT - 1);
        end
        else if (st_ff.busy)
        begin
            if (st_ff.cnt == '0)
                nxt_st.busy = 1'b0;
            else
                nxt_st.cnt = st_ff.cnt - 1'b1;
        end
    end

    // state register
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign busy_o = st_ff.busy;

    // busy stays up while the count is still running
    AST_BUSY_HOLDS: assert property (@(posedge CLK_I) disable iff (RST_I)
        (st_ff.busy && st_ff.cnt != '0 && !start_i) |=> busy_o)
        else $error("busy dropped before count ended");
endmodule // pnvm_busy_timer
`default_nettype wire

/* File: testbench/pnvm_prog_bus.sv */
// data bus wire between the programmer and the port
// assumes the programmer drives only while the device is released
`timescale 1ns/1ps
`default_nettype none
module pnvm_prog_bus (
    // clock
    input  wire logic       CLK_I,
    // programmer side
    input  wire logic [7:0] prog_data_i,
    input  wire logic       prog_oe_i,
    // device side
    input  wire logic [7:0] dev_data_i,
    input  wire logic       dev_oe_i,
    // resolved wire
    output logic      [7:0] bus_o
);
    logic [7:0] last_ff; // last wire level
    // remember the wire so a floating bus can show its inverse
    always_ff @(posedge CLK_I)
    begin
        last_ff <= bus_o;
    end
    // floating wire toggles so stale data never looks valid
    always_comb
    begin
        if (prog_oe_i)
            bus_o = prog_data_i;
        else if (dev_oe_i)
            bus_o = dev_data_i;
        else
            bus_o = ~last_ff;
    end
endmodule // pnvm_prog_bus
`default_nettype wire

/* File: testbench/testbench.sv */
// programmer-side bench for the parallel programming port
// assumes shortened busy counts and the bus model beside the port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pnvm_pkg::*;
    localparam int WRN = 20; // write busy cycles
    localparam int CEN = 40; // erase busy cycles
    logic       clk, rst, xh, xl, b1, b2, ld, pg, wn, oen, den, doe, rdy;
    logic [7:0] dd, dq, bus;
    int         err_total, n_compared, cyc, i;
    // device under test
    pnvm_port #(.WR_CNT(WRN), .CE_CNT(CEN), .SIG_BYTE0(8'h11),
        .SIG_BYTE1(8'h22), .SIG_BYTE2(8'h33), .CAL_BYTE(8'h44)) dut (
        .CLK_I(clk), .RST_I(rst), .ACTION_SELECT_HI_I(xh),
        .ACTION_SELECT_LO_I(xl), .BYTE_SELECT_ONE_I(b1),
        .BYTE_SELECT_TWO_I(b2), .LOAD_STROBE_I(ld),
        .PAGE_LOAD_STROBE_I(pg), .WRITE_STROBE_N_I(wn),
        .OUTPUT_ENABLE_N_I(oen), .DATA_I(bus), .DATA_O(dq),
        .DATA_OE_O(doe), .READY_BUSY_N_O(rdy));
    // shared data wire
    pnvm_prog_bus bus_model (.CLK_I(clk), .prog_data_i(dd),
        .prog_oe_i(den), .dev_data_i(dq), .dev_oe_i(doe), .bus_o(bus));
    ////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 10000)
        begin
            err_total++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////
    // compare and report
    task automatic check(input string nm, input logic [15:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
            err_total++;
        end
    endtask
    task automatic end_of_test();
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // load strobe pulse with action, byte select one and data
    task automatic load(input logic [1:0] a, input logic s, logic [7:0] d);
        @(posedge clk);
        {xh, xl, b1, b2, dd, den, ld} <= {a, s, 1'b0, d, 2'b11};
        @(posedge clk);
        ld <= 1'b0;
        @(posedge clk);
        den <= 1'b0;
    endtask
    // page load pulse
    task automatic pload(input logic s);
        @(posedge clk);
        {b1, pg} <= {s, 1'b1};
        @(posedge clk);
        pg <= 1'b0;
    endtask
    // write pulse, optional second pulse while busy, busy length check
    task automatic write(input logic [1:0] s, input int e, input bit again);
        int n;
        n = 0;
        @(posedge clk);
        {b2, b1, wn} <= {s, 1'b0};
        @(posedge clk);
        wn <= 1'b1;
        do
        begin
            @(posedge clk);
            wn <= !(again && n == 5);
            #1;
            n++;
        end while (rdy !== 1'b1 && n < 200);
        // n counts the edges after the accepting edge up to ready high
        check("busy", 16'(e), 16'(n));
    endtask
    // output enable low with selects, then compare the wire
    task automatic rd(input logic [1:0] s, input logic [7:0] e, logic d);
        @(posedge clk);
        {b2, b1, oen} <= {s, 1'b0};
        repeat (2) @(posedge clk);
        #1;
        check("drive", {15'h0, d}, {15'h0, doe});
        if (d)
            check("data", {8'h0, e}, {8'h0, bus});
        @(posedge clk);
        oen <= 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        // cycle counter belongs to the hang guard alone; int starts at 0
        {rst, xh, xl, b1, b2, ld, pg, den, dd} = '0;
        {rst, wn, oen} = 3'h7;
        err_total = 0;
        n_compared = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check("ready", 16'h1, {15'h0, rdy});
        // flash page fill, commit, end, read back
        load(ACT_CMD, 1'b0, CMD_WR_FLASH);
        load(ACT_ADDR, 1'b1, 8'h00);
        for (i = 0; i < 4; i++)
        begin
            load(ACT_ADDR, 1'b0, 8'(i));
            load(ACT_DATA, 1'b0, 8'(8'h50 + i));
            load(ACT_DATA, 1'b1, 8'(8'ha0 + i));
            pload(1'b1);
        end
        write(2'h0, WRN, 1'b0);
        load(ACT_CMD, 1'b0, CMD_NOP);
        load(ACT_CMD, 1'b0, CMD_RD_FLASH);
        for (i = 0; i < 4; i++)
        begin
            load(ACT_ADDR, 1'b0, 8'(i));
            rd(2'h0, 8'(8'h50 + i), 1'b1);
            rd(2'h1, 8'(8'ha0 + i), 1'b1);
        end
        // eeprom page fill with byte select one low
        load(ACT_CMD, 1'b0, CMD_WR_EE);
        for (i = 0; i < 4; i++)
        begin
            load(ACT_ADDR, 1'b0, 8'(4 + i));
            load(ACT_DATA, 1'b0, 8'(8'hc0 + i));
            pload(1'b0);
        end
        write(2'h0, WRN, 1'b0);
        load(ACT_CMD, 1'b0, CMD_RD_EE);
        for (i = 0; i < 4; i++)
        begin
            load(ACT_ADDR, 1'b0, 8'(4 + i));
            rd(2'h0, 8'(8'hc0 + i), 1'b1);
        end
        rd(2'h1, 8'h00, 1'b0);
        // fuses low, high, extended; a second strobe while busy
        load(ACT_CMD, 1'b0, CMD_WR_FUSE);
        load(ACT_DATA, 1'b0, 8'ha5);
        write(2'h0, WRN, 1'b1);
        load(ACT_DATA, 1'b0, 8'h3c);
        write(WSEL_HI, WRN, 1'b0);
        load(ACT_DATA, 1'b0, 8'h0f);
        write(WSEL_EXT, WRN, 1'b0);
        // lock mode three then boot locks and erase attempt
        load(ACT_CMD, 1'b0, CMD_WR_LOCK);
        load(ACT_DATA, 1'b0, 8'hfc);
        write(2'h0, WRN, 1'b0);
        load(ACT_DATA, 1'b0, 8'hc3);
        write(2'h0, WRN, 1'b0);
        load(ACT_DATA, 1'b0, 8'hff);
        write(2'h0, WRN, 1'b0);
        load(ACT_CMD, 1'b0, CMD_RD_FUSE);
        rd(SEL_FUSE_LO, 8'ha5, 1'b1);
        rd(SEL_FUSE_HI, 8'h3c, 1'b1);
        rd(SEL_FUSE_EXT, 8'h0f, 1'b1);
        rd(SEL_LOCK, 8'hfc, 1'b1);
        // chip erase clears locks and flash, keeps fuses
        load(ACT_CMD, 1'b0, CMD_ERASE);
        write(2'h0, CEN, 1'b0);
        load(ACT_CMD, 1'b0, CMD_RD_FUSE);
        rd(SEL_LOCK, 8'hff, 1'b1);
        rd(SEL_FUSE_LO, 8'ha5, 1'b1);
        load(ACT_CMD, 1'b0, CMD_RD_FLASH);
        load(ACT_ADDR, 1'b0, 8'h00);
        rd(2'h1, 8'hff, 1'b1);
        // signature and calibration; idle action must not load
        load(ACT_CMD, 1'b0, CMD_RD_SIG);
        load(2'h3, 1'b0, CMD_RD_FLASH);
        for (i = 0; i < 3; i++)
        begin
            load(ACT_ADDR, 1'b0, 8'(i));
            rd(2'h0, 8'(8'h11 * (i + 1)), 1'b1);
        end
        load(ACT_ADDR, 1'b0, SIG_ADDR_0);
        rd(2'h1, 8'h44, 1'b1);
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
